// File: bench/panel_model.sv
// start and stop pins of the operator panel and sensors
module panel_model (
    // clock
    input wire logic clk_i,
    // pins
    output logic start_o,
    output logic stop_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        start_o = 1'b0;
        stop_o = 1'b0;
    end
    // a press holds the level long enough for the synchroniser
    task automatic press(input logic stop);
        @(posedge clk_i);
        if (stop) stop_o <= 1'b1;
        else start_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        start_o <= 1'b0;
        stop_o <= 1'b0;
    endtask
endmodule

// File: bench/rct_timer_chk.sv
// port assertions of the repeat cycle interval timer
// ----------------------------------------
// checker
// ----------------------------------------
module rct_timer_chk
    import rct_pkg::*;
#(
    parameter int TICK_CYCLES = 10
) (
    // watched inputs
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic rd_i,
    input wire logic timer_reset_i,
    input wire logic restore_i,
    // watched outputs
    input wire logic [31:0] rdata_o,
    input wire logic [18:0] disp_sec_o,
    input wire logic [2:0] state_o,
    input wire logic [6:0] cycles_done_o,
    input wire logic tick_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
        else $error("read data outside its slot");
    a_tick_gap: assert property (tick_o |=> !tick_o [*8])
        else $error("second tick too soon");
    a_time_ceiling: assert property (disp_sec_o <= 19'h57E3F)
        else $error("time above ceiling");
    a_state_legal: assert property (state_o <= 3'h4)
        else $error("unknown timer state");
    a_count_step: assert property (
        (state_o == ST_RUN && $past(state_o) == ST_RUN
        && $changed(disp_sec_o) && $stable(cycles_done_o)) |->
        (disp_sec_o == $past(disp_sec_o) + 19'h1
        || disp_sec_o + 19'h1 == $past(disp_sec_o)))
        else $error("count moved by more than one");
    a_cycles_step: assert property ($changed(cycles_done_o) |->
        (cycles_done_o == $past(cycles_done_o) + 7'h1
        || cycles_done_o == 7'h0))
        else $error("cycle count jumped");
    a_reset_state: assert property (
        timer_reset_i |=> state_o == ST_RESET)
        else $error("timer reset ignored");
    a_done_holds: assert property (
        (state_o == ST_DONE && !timer_reset_i && !restore_i)
        |=> state_o == ST_DONE)
        else $error("left complete without reset");
endmodule
bind repeat_cycle_interval_timer rct_timer_chk #(
    .TICK_CYCLES(TICK_CYCLES)
) i_chk (
    .clk_i(clk_i), .rst_i(rst_i), .rd_i(rd_i),
    .timer_reset_i(timer_reset_i), .restore_i(restore_i),
    .rdata_o(rdata_o), .disp_sec_o(disp_sec_o), .state_o(state_o),
    .cycles_done_o(cycles_done_o), .tick_o(tick_o)
);

// File: bench/repeat_cycle_interval_timer_bench.sv
// testbench of the repeat cycle interval timer
module repeat_cycle_interval_timer_bench import rct_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i, rst_i, wr_i, rd_i, start_i, stop_i, tick_o;
    logic timer_reset_i, restore_i, op_adj_req_i, op_write_i;
    logic [7:0] addr_i;
    logic [31:0] wdata_i, rdata_o, op_code_i;
    logic [18:0] op_setpoint_i, op_pause_i, disp_sec_o;
    logic [1:0] disp_fmt_o;
    logic [2:0] state_o;
    logic [6:0] cycles_done_o;
    int n_errors, checks, cyc, n_delay, last_tick;
    logic in_dly;
    repeat_cycle_interval_timer #(.TICK_CYCLES(10)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .start_i(start_i), .stop_i(stop_i),
        .timer_reset_i(timer_reset_i), .restore_i(restore_i),
        .op_adj_req_i(op_adj_req_i), .op_code_i(op_code_i),
        .op_write_i(op_write_i), .op_setpoint_i(op_setpoint_i),
        .op_pause_i(op_pause_i), .disp_sec_o(disp_sec_o),
        .disp_fmt_o(disp_fmt_o), .state_o(state_o),
        .cycles_done_o(cycles_done_o), .tick_o(tick_o));
    panel_model i_panel (.clk_i(clk_i), .start_o(start_i), .stop_o(stop_i));
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic tally_and_finish();
        if (n_errors == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    always @(negedge clk_i) begin
        cyc++;
        if (state_o === ST_DELAY && !in_dly) n_delay++;
        in_dly = (state_o === ST_DELAY);
        if (tick_o === 1'b1 && last_tick != 0) begin
            checks++;
            if (cyc - last_tick != 10) begin
                n_errors++;
                $display("Error at %0t: tick gap %0d", $time, cyc - last_tick);
            end
        end
        if (tick_o === 1'b1) last_tick = cyc;
        if (cyc == 20000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        #1;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 chk(rdata_o & m, e);
    endtask
    task automatic pulse(input int k);
        @(posedge clk_i);
        case (k)
            0: timer_reset_i <= 1'b1;
            1: restore_i <= 1'b1;
            2: op_adj_req_i <= 1'b1;
            default: op_write_i <= 1'b1;
        endcase
        @(posedge clk_i);
        {timer_reset_i, restore_i, op_adj_req_i, op_write_i} <= 4'h0;
        #1;
    endtask
    task automatic wait_st(input logic [2:0] s);
        for (int i = 0; i < 2000 && state_o !== s; i++) @(posedge clk_i) #1;
        chk(32'(state_o), 32'(s));
    endtask
    task automatic go(input logic stop, input logic [2:0] s);
        i_panel.press(stop);
        wait_st(s);
    endtask
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        {rst_i, wr_i, rd_i, timer_reset_i, restore_i} = 5'h10;
        {op_adj_req_i, op_write_i, addr_i, wdata_i} = '0;
        {op_code_i, op_setpoint_i, op_pause_i} = '0;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc(8'h00, 32'hFFFFFFFF, 32'h0);
        rdc(8'h10, 32'hFFFFFFFF, 32'h30303030);
        rdc(8'h40, 32'hFFFFFFFF, 32'h0);
        wr(8'h0C, 32'hC8);
        rdc(8'h0C, 32'hFFFFFFFF, 32'h63);
        i_panel.press(1'b0);
        repeat (8) @(posedge clk_i);
        wait_st(ST_RESET);
        wr(8'h04, 32'h3);
        go(1'b0, ST_RUN);
        wait_st(ST_DONE);
        chk(32'(disp_sec_o), 32'h3);
        pulse(0);
        wr(8'h08, 32'h2);
        wr(8'h0C, 32'h2);
        wr(8'h00, 32'h3);
        n_delay = 0;
        go(1'b0, ST_DONE);
        chk(32'(disp_sec_o), 32'h0);
        chk(32'(cycles_done_o), 32'h2);
        chk(32'(n_delay), 32'h1);
        wr(8'h00, 32'h2);
        rdc(8'h0C, 32'hFFFFFFFF, 32'h2);
        wr(8'h00, 32'h4);
        chk(32'(disp_fmt_o), 32'(FMT_HMS));
        wr(8'h04, 32'h78);
        wr(8'h08, 32'h3C);
        chk(32'(disp_fmt_o), 32'(FMT_HM));
        wr(8'h00, 32'hC);
        chk(32'(disp_fmt_o), 32'(FMT_S));
        pulse(0);
        wr(8'h04, 32'h3);
        wr(8'h08, 32'h2);
        wr(8'h00, 32'h3);
        go(1'b0, ST_DELAY);
        chk(32'(cycles_done_o), 32'h1);
        wait_st(ST_RUN);
        pulse(1);
        wait_st(ST_DONE);
        i_panel.press(1'b0);
        repeat (8) @(posedge clk_i);
        wait_st(ST_DONE);
        pulse(0);
        chk(32'(cycles_done_o), 32'h0);
        wr(8'h04, 32'h28);
        wr(8'h00, 32'h10);
        go(1'b0, ST_RUN);
        go(1'b1, ST_PAUSED);
        go(1'b0, ST_RUN);
        pulse(1);
        chk(32'(state_o), 32'(ST_RUN));
        repeat (4) @(posedge clk_i);
        pulse(1);
        wait_st(ST_PAUSED);
        wr(8'h00, 32'h20);
        go(1'b0, ST_RUN);
        repeat (4) @(posedge clk_i);
        pulse(1);
        chk(32'(state_o), 32'(ST_RUN));
        wr(8'h00, 32'hC0);
        op_code_i <= 32'h31313131;
        pulse(2);
        rdc(8'h14, 32'h10, 32'h0);
        op_code_i <= 32'h30303030;
        pulse(2);
        rdc(8'h14, 32'h10, 32'h10);
        op_setpoint_i <= 19'h5A;
        op_pause_i <= 19'h1E;
        pulse(3);
        rdc(8'h04, 32'hFFFFFFFF, 32'h5A);
        rdc(8'h08, 32'hFFFFFFFF, 32'h1E);
        tally_and_finish();
    end
endmodule

// File: verilog/rct_cfg.svh
// offsets, field positions, reset values and timing counts of the timer
`ifndef RCT_CFG_SVH
`define RCT_CFG_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define RCT_CTRL_OFS 8'h00
`define RCT_SETPOINT_OFS 8'h04
`define RCT_PAUSE_OFS 8'h08
`define RCT_CYCLES_OFS 8'h0C
`define RCT_CODE_OFS 8'h10
`define RCT_STATUS_OFS 8'h14
`define RCT_COUNT_OFS 8'h18
`define RCT_DONE_OFS 8'h1C
// ----------------------------------------
// control fields
// ----------------------------------------
`define RCT_CTRL_REPEAT 0
`define RCT_CTRL_DOWN 1
`define RCT_CTRL_FMT_LO 2
`define RCT_CTRL_FMT_HI 3
`define RCT_CTRL_POL_LO 4
`define RCT_CTRL_POL_HI 5
`define RCT_CTRL_ADJ 6
`define RCT_CTRL_CODE 7
// ----------------------------------------
// limits and reset values
// ----------------------------------------
`define RCT_MAX_SEC 19'h57E3F
`define RCT_MAX_HM_SEC 19'h57E04
`define RCT_SEC_PER_MIN 19'h0003C
`define RCT_MAX_CYCLES 7'h63
`define RCT_CODE_RST 32'h30303030
`define RCT_CTRL_RST 8'h00
// ----------------------------------------
// timing
// ----------------------------------------
`define RCT_TICK_NS 1000000000
`define RCT_CLK_NS 5
`endif

// File: verilog/rct_pkg.sv
// types of the repeat cycle interval timer
package rct_pkg;
    typedef enum logic [2:0] {
        ST_RESET, ST_RUN, ST_PAUSED, ST_DELAY, ST_DONE
    } tstate_e;
    typedef enum logic [1:0] {
        FMT_HMS, FMT_HM, FMT_MS, FMT_S
    } fmt_e;
    typedef enum logic [1:0] {
        POL_HALT, POL_PAUSE, POL_CONTINUE, POL_SPARE
    } policy_e;
    typedef logic [18:0] sec_t;
endpackage

// File: verilog/repeat_cycle_interval_timer.sv
// repeat cycle interval timer core with register port
//
// Operation
// - elapsed count never exceeds 99:59:59 in any format.
// - hours-minutes format only when setpoint and pause are multiples of 60.
// - count up from zero to setpoint or down from setpoint to zero.
// - down shows remaining time, up shows elapsed time.
// - start requests ignored while setpoint is zero.
// - repeat count 1 to 99 cycles, 00 repeats endlessly.
// - restart pause between cycles, limited by the selected format.
// - restart pause shown in the same format as other times.
// - no restart pause after the final cycle.
// - repeat enable bit leaves count and pause settings untouched.
// - operator may adjust setpoint and pause from display mode.
// - optional four character code must match before adjustment.
// - three power restore policies: halt, pause, continue.
// - halt policy restores to complete and refuses start until reset.
// - reset after halted restore discards completed cycle count.
// - pause policy restores paused, starts at once if start is active.
// - continue policy carries on timing with no operator action.
// - four display formats: h-m-s, h-m, m-s, seconds.
// - five states: reset, running, paused, restart pause, complete.
//
// Local design decisions: the register offsets and the address-and-strobe port.
`include "rct_cfg.svh"
module repeat_cycle_interval_timer
    import rct_pkg::*;
#(
    parameter int TICK_CYCLES = `RCT_TICK_NS / `RCT_CLK_NS
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // conditioned start and stop pins
    input wire logic start_i,
    input wire logic stop_i,
    // timer reset and power restore pulses
    input wire logic timer_reset_i,
    input wire logic restore_i,
    // operator adjustment from display mode
    input wire logic op_adj_req_i,
    input wire logic [31:0] op_code_i,
    input wire logic op_write_i,
    input wire logic [18:0] op_setpoint_i,
    input wire logic [18:0] op_pause_i,
    // display and state
    output logic [18:0] disp_sec_o,
    output logic [1:0] disp_fmt_o,
    output logic [2:0] state_o,
    output logic [6:0] cycles_done_o,
    output logic tick_o
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [1:0] start_sync;
        logic [1:0] stop_sync;
        logic start_prev;
        logic stop_prev;
        logic [27:0] presc;
        logic tick;
        logic [7:0] ctrl;
        sec_t setpoint;
        sec_t pause;
        logic [6:0] cycles;
        logic [31:0] code;
        tstate_e tstate;
        sec_t count;
        sec_t pause_cnt;
        logic [6:0] done_cnt;
        logic halted;
        logic adj_open;
        logic [31:0] rdata;
    } st_s;

    st_s s_q, s_d;
    logic start_lvl, start_ev, stop_ev, down, hm_ok, more;
    fmt_e fmt_eff;
    sec_t sec_max, pause_lim, disp;
    logic [6:0] done_inc;

    // saturate a whole bus word, upper bits included, at a ceiling
    function automatic sec_t clamp(input logic [31:0] v, input sec_t lim);
        if (v > {13'h0000, lim}) begin
            clamp = lim;
        end else begin
            clamp = v[18:0];
        end
    endfunction

    // ----------------------------------------
    // derived terms
    // ----------------------------------------
    always_comb begin
        start_lvl = s_q.start_sync[1];
        start_ev = start_lvl && !s_q.start_prev;
        stop_ev = s_q.stop_sync[1] && !s_q.stop_prev;
        down = s_q.ctrl[`RCT_CTRL_DOWN];
        hm_ok = (s_q.setpoint % `RCT_SEC_PER_MIN == 19'h00000) &&
            (s_q.pause % `RCT_SEC_PER_MIN == 19'h00000);
        fmt_eff = fmt_e'(s_q.ctrl[`RCT_CTRL_FMT_HI:`RCT_CTRL_FMT_LO]);
        if (fmt_eff == FMT_HM && !hm_ok) begin
            fmt_eff = FMT_HMS;
        end
        // whole-minute format tops out at 99:59
        sec_max = (fmt_eff == FMT_HM) ? `RCT_MAX_HM_SEC : `RCT_MAX_SEC;
        pause_lim = sec_max;
        done_inc = s_q.done_cnt + 7'h01;
        // cycles left after the one now ending; 00 repeats for ever
        more = s_q.ctrl[`RCT_CTRL_REPEAT] &&
            (s_q.cycles == 7'h00 || done_inc < s_q.cycles);
        if (s_q.tstate == ST_DELAY) begin
            disp = s_q.pause_cnt;
        end else if (s_q.tstate == ST_RESET) begin
            disp = down ? s_q.setpoint : 19'h00000;
        end else begin
            disp = s_q.count;
        end
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        s_d = s_q;
        // two-stage sync of pins, edges taken on the second stage
        s_d.start_sync = {s_q.start_sync[0], start_i};
        s_d.stop_sync = {s_q.stop_sync[0], stop_i};
        s_d.start_prev = s_q.start_sync[1];
        s_d.stop_prev = s_q.stop_sync[1];
        // one-second tick
        // free running: a timer reset leaves its phase alone
        s_d.tick = 1'b0;
        if (s_q.presc == 28'(TICK_CYCLES - 1)) begin
            s_d.presc = 28'h0000000;
            s_d.tick = 1'b1;
        end else begin
            s_d.presc = s_q.presc + 28'h0000001;
        end
        // register writes
        s_d.rdata = 32'h00000000;
        if (wr_i) begin
            unique case (addr_i)
                `RCT_CTRL_OFS: begin
                    s_d.ctrl = wdata_i[7:0];
                end
                `RCT_SETPOINT_OFS: begin
                    s_d.setpoint = clamp(wdata_i, sec_max);
                end
                `RCT_PAUSE_OFS: begin
                    s_d.pause = clamp(wdata_i, pause_lim);
                end
                `RCT_CYCLES_OFS: begin
                    if (wdata_i > {25'h0000000, `RCT_MAX_CYCLES}) begin
                        s_d.cycles = `RCT_MAX_CYCLES;
                    end else begin
                        s_d.cycles = wdata_i[6:0];
                    end
                end
                `RCT_CODE_OFS: begin
                    s_d.code = wdata_i;
                end
                default: ;
            endcase
        end
        // register reads, data stand one cycle later
        if (rd_i) begin
            unique case (addr_i)
                `RCT_CTRL_OFS: s_d.rdata = {24'h000000, s_q.ctrl};
                `RCT_SETPOINT_OFS: s_d.rdata = {13'h0000, s_q.setpoint};
                `RCT_PAUSE_OFS: s_d.rdata = {13'h0000, s_q.pause};
                `RCT_CYCLES_OFS: s_d.rdata = {25'h0000000, s_q.cycles};
                `RCT_CODE_OFS: s_d.rdata = s_q.code;
                `RCT_STATUS_OFS: begin
                    s_d.rdata = {25'h0000000, fmt_eff, s_q.adj_open,
                        s_q.halted, s_q.tstate};
                end
                `RCT_COUNT_OFS: s_d.rdata = {13'h0000, disp};
                `RCT_DONE_OFS: s_d.rdata = {25'h0000000, s_q.done_cnt};
                default: s_d.rdata = 32'h00000000;
            endcase
        end
        // operator adjustment from display mode
        // a write closes access; a request in the same cycle reopens it
        if (op_write_i && s_q.adj_open) begin
            s_d.setpoint = clamp({13'h0000, op_setpoint_i}, sec_max);
            s_d.pause = clamp({13'h0000, op_pause_i}, pause_lim);
            s_d.adj_open = 1'b0;
        end
        if (op_adj_req_i && s_q.ctrl[`RCT_CTRL_ADJ]) begin
            s_d.adj_open = !s_q.ctrl[`RCT_CTRL_CODE] ||
                (op_code_i == s_q.code);
        end
        // timer states
        unique case (s_q.tstate)
            ST_RESET: begin
                if (start_ev && s_q.setpoint != 19'h00000 &&
                    !s_q.halted) begin
                    s_d.tstate = ST_RUN;
                    s_d.count = down ? s_q.setpoint : 19'h00000;
                    s_d.done_cnt = 7'h00;
                end
            end
            ST_RUN: begin
                if (stop_ev) begin
                    s_d.tstate = ST_PAUSED;
                end else if (s_q.tick) begin
                    // a setpoint cleared mid-cycle must not wrap the count
                    if (!down) begin
                        s_d.count = s_q.count + 19'h00001;
                    end else if (s_q.count != 19'h00000) begin
                        s_d.count = s_q.count - 19'h00001;
                    end
                    if ((down && s_q.count <= 19'h00001) ||
                        (!down && s_q.count + 19'h00001 >= s_q.setpoint) ||
                        (!down && s_q.count >= `RCT_MAX_SEC)) begin
                        s_d.done_cnt = done_inc;
                        if (more && s_q.pause != 19'h00000) begin
                            s_d.tstate = ST_DELAY;
                            s_d.pause_cnt = s_q.pause;
                        end else if (more) begin
                            s_d.count = down ? s_q.setpoint : 19'h00000;
                        end else begin
                            s_d.tstate = ST_DONE;
                        end
                    end
                end
            end
            ST_PAUSED: begin
                if (start_ev && s_q.setpoint != 19'h00000) begin
                    s_d.tstate = ST_RUN;
                end
            end
            ST_DELAY: begin
                if (s_q.tick) begin
                    s_d.pause_cnt = s_q.pause_cnt - 19'h00001;
                    if (s_q.pause_cnt <= 19'h00001) begin
                        s_d.tstate = ST_RUN;
                        s_d.count = down ? s_q.setpoint : 19'h00000;
                    end
                end
            end
            ST_DONE: ;
        endcase
        // power restore
        if (restore_i && s_q.tstate != ST_RESET) begin
            unique case (policy_e'(
                s_q.ctrl[`RCT_CTRL_POL_HI:`RCT_CTRL_POL_LO]))
                POL_HALT: begin
                    s_d.tstate = ST_DONE;
                    s_d.halted = 1'b1;
                end
                POL_PAUSE: begin
                    s_d.tstate = start_lvl ? ST_RUN : ST_PAUSED;
                end
                POL_CONTINUE: ;
                POL_SPARE: ;
            endcase
        end
        // timer reset
        // a timer reset wins over a restore in the same cycle
        if (timer_reset_i) begin
            s_d.tstate = ST_RESET;
            s_d.count = 19'h00000;
            s_d.pause_cnt = 19'h00000;
            s_d.done_cnt = 7'h00;
            s_d.halted = 1'b0;
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
            s_q.ctrl <= `RCT_CTRL_RST;
            s_q.code <= `RCT_CODE_RST;
            s_q.tstate <= ST_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign rdata_o = s_q.rdata;
    assign disp_sec_o = disp;
    assign disp_fmt_o = fmt_eff;
    assign state_o = s_q.tstate;
    assign cycles_done_o = s_q.done_cnt;
    assign tick_o = s_q.tick;
endmodule
